/* File: hw/ais_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps
module ais_fifo
   import ais_pkg::*;
#(
   parameter int WIDTH = 22,
   parameter int DEPTH = 8
)
(
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     inValid,
   output logic                          inReady,
   input  wire logic [WIDTH-1:0]         inData,
   output logic                          outValid,
   input  wire logic                     outReady,
   output logic [WIDTH-1:0]              outData,
   output logic [$clog2(DEPTH):0]        count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr;
   logic [AW:0]      rdPtr;
   logic [AW:0]      next_wrPtr;
   logic [AW:0]      next_rdPtr;
   logic             push;
   logic             pop;

   // full when pointers differ only in the wrap bit
   always_comb
   begin
      inReady    = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
      outValid   = wrPtr != rdPtr;
      outData    = mem[rdPtr[AW-1:0]];
      count      = wrPtr - rdPtr;
      push       = inValid && inReady;
      pop        = outValid && outReady;
      next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
   end

   // pointers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
      end
      else
      begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
      end
   end

   // storage, no reset needed
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wrPtr[AW-1:0]] <= inData;
   end
endmodule

/* File: hw/ais_pkg.sv */
// types shared by the analog input smoothing block
// assumes the constants header is included by each user
package ais_pkg;
   typedef logic [11:0] ais_sample_t;
   typedef logic [7:0]  ais_pin_t;
   typedef enum logic {AIS_KIND_ANALOG, AIS_KIND_RELAY} ais_kind_t;
   typedef enum logic [1:0] {AIS_RD_IDLE, AIS_RD_HIT, AIS_RD_MISS} ais_rd_t;
endpackage

/* File: hw/ais_regs.svh */
// constants for the analog input smoothing block
// assumes a 200 MHz clock and 12-bit samples spanning 0 to 10 V
`ifndef AIS_REGS_SVH
`define AIS_REGS_SVH
`define AIS_SAMPLE_W       12
`define AIS_FRAC_BITS      16
`define AIS_ACC_W          28
`define AIS_SHIFT_RESET    5'h03
`define AIS_SHIFT_MAX      5'h10
`define AIS_HYST_RESET     12'h004
`define AIS_CHANNELS       4
`define AIS_ANALOG_IN_BASE 8'h04
`define AIS_ANALOG_IN_LAST 8'h07
`define AIS_RELAY_IN_BASE  8'h08
`define AIS_RELAY_IN_LAST  8'h0F
`define AIS_FIFO_DEPTH     8
`define AIS_FIFO_HEADROOM  3
`define AIS_CLK_MHZ        200
`define AIS_READOUT_TYP_MS 5
`define AIS_READOUT_MAX_MS 40
`define AIS_READOUT_MAX_CYC (`AIS_READOUT_MAX_MS * 1000 * `AIS_CLK_MHZ)
`endif

/* File: hw/ais_smooth_chan.sv */
// one channel: recursive lowpass followed by hysteresis
// assumes one sample strobe at most per cycle and settings in range
`timescale 1ns/100ps
`include "ais_regs.svh"
module ais_smooth_chan
   import ais_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sampleStrobe,
   input  wire ais_sample_t sampleData,
   input  wire logic [4:0]  shiftSetting,
   input  wire ais_sample_t hystWindow,
   output logic             acceptStrobe,
   output ais_sample_t      activeValue
);
   logic [`AIS_ACC_W-1:0] acc;
   logic [`AIS_ACC_W-1:0] next_acc;
   logic [`AIS_ACC_W-1:0] scaledIn;
   ais_sample_t           next_activeValue;
   ais_sample_t           filtered;
   ais_sample_t           distance;
   logic                  primed;
   logic                  next_primed;
   logic                  next_acceptStrobe;

   // filter, then hysteresis on the new filtered value
   always_comb
   begin
      scaledIn          = {sampleData, {`AIS_FRAC_BITS{1'b0}}} >> shiftSetting;
      next_acc          = acc;
      next_activeValue  = activeValue;
      next_primed       = primed;
      next_acceptStrobe = 1'b0;
      if (sampleStrobe)
         next_acc = acc - (acc >> shiftSetting) + scaledIn;
      filtered = next_acc[`AIS_ACC_W-1:`AIS_FRAC_BITS];
      distance = (filtered > activeValue) ? filtered - activeValue
                                          : activeValue - filtered;
      if (sampleStrobe && (!primed || distance > hystWindow))
      begin
         next_activeValue  = filtered;
         next_primed       = 1'b1;
         next_acceptStrobe = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc          <= '0;
         activeValue  <= '0;
         primed       <= 1'b0;
         acceptStrobe <= 1'b0;
      end
      else
      begin
         acc          <= next_acc;
         activeValue  <= next_activeValue;
         primed       <= next_primed;
         acceptStrobe <= next_acceptStrobe;
      end
   end
endmodule

/* File: hw/ais_top.sv */
// analog input smoothing: four channels, pin numbering, fifo to the reader
// each channel filters and thresholds its own samples; accepted values are
// queued with their global pin number, and a pin can also be read directly
// assumes adc samples arrive synchronous to clk with a channel number
// assumes the host paces reads and keeps settings and offset steady in use
`timescale 1ns/100ps
`include "ais_regs.svh"
module ais_top
   import ais_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sampleValid,
   input  wire logic [1:0]  sampleChan,
   input  wire ais_sample_t sampleData,
   output logic             sampleReady,
   input  wire logic        cfgWrite,
   input  wire logic [1:0]  cfgChan,
   input  wire logic [4:0]  cfgShift,
   input  wire ais_sample_t cfgHyst,
   output logic             cfgReject,
   input  wire ais_kind_t   addonKind,
   input  wire ais_pin_t    addonOffset,
   input  wire logic        readReq,
   input  wire ais_pin_t    readPin,
   output logic             readValid,
   output logic             readMiss,
   output ais_sample_t      readData,
   output logic             outValid,
   output logic [1:0]       outChan,
   output ais_pin_t         outPin,
   output ais_sample_t      outData,
   input  wire logic        outReady
);
   // fifo word from the top down: channel, global pin, accepted value
   localparam int VAL_W  = `AIS_SAMPLE_W;
   localparam int PIN_LO = VAL_W;
   localparam int PIN_HI = PIN_LO + 7;
   localparam int CH_LO  = PIN_HI + 1;
   localparam int CH_HI  = CH_LO + 1;
   localparam int FW     = CH_HI + 1;
   // fill count and the level at which intake pauses for samples in flight
   localparam int CW = $clog2(`AIS_FIFO_DEPTH) + 1;
   localparam logic [CW-1:0] READY_LIMIT = CW'(`AIS_FIFO_DEPTH - `AIS_FIFO_HEADROOM);

   // per-channel settings
   logic [4:0]  shiftSet   [`AIS_CHANNELS];
   logic [4:0]  next_shiftSet [`AIS_CHANNELS];
   ais_sample_t hystSet    [`AIS_CHANNELS];
   ais_sample_t next_hystSet  [`AIS_CHANNELS];
   logic        next_cfgReject;
   logic        cfgLegal;

   // channel pipeline
   logic [`AIS_CHANNELS-1:0] chanStrobe;
   logic [`AIS_CHANNELS-1:0] chanAccept;
   ais_sample_t              chanActive [`AIS_CHANNELS];
   logic [1:0]               chanDelayed;
   logic [1:0]               next_chanDelayed;
   logic                     next_sampleReady;
   logic                     takeSample;

   // fifo and output stage
   logic          fifoInValid;
   logic          fifoInReady;
   logic [FW-1:0] fifoInData;
   logic          fifoOutValid;
   logic          fifoOutReady;
   logic [FW-1:0] fifoOutData;
   logic [CW-1:0] fifoCount;
   ais_pin_t      pushPin;
   logic          next_outValid;
   logic [1:0]    next_outChan;
   ais_pin_t      next_outPin;
   ais_sample_t   next_outData;
   logic [1:0]    headChan;
   ais_pin_t      headPin;
   ais_sample_t   headData;

   // read port
   ais_rd_t     next_readState;
   ais_sample_t next_readData;
   ais_pin_t    localPin;
   ais_pin_t    analogSlot;
   logic        pinBelowAddon;
   logic        pinAnalogIn;

   // settings: order above 16 is refused, old value kept
   always_comb
   begin
      next_cfgReject = 1'b0;
      cfgLegal       = cfgShift <= `AIS_SHIFT_MAX;
      for (int i = 0; i < `AIS_CHANNELS; i++)
      begin
         next_shiftSet[i] = shiftSet[i];
         next_hystSet[i]  = hystSet[i];
      end
      if (cfgWrite)
      begin
         if (!cfgLegal)
            next_cfgReject = 1'b1;
         else
         begin
            next_shiftSet[cfgChan] = cfgShift;
            next_hystSet[cfgChan]  = cfgHyst;
         end
      end
   end

   // settings registers, reset to order 3 and a 4-code window
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < `AIS_CHANNELS; i++)
         begin
            shiftSet[i] <= `AIS_SHIFT_RESET;
            hystSet[i]  <= `AIS_HYST_RESET;
         end
         cfgReject <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < `AIS_CHANNELS; i++)
         begin
            shiftSet[i] <= next_shiftSet[i];
            hystSet[i]  <= next_hystSet[i];
         end
         cfgReject <= next_cfgReject;
      end
   end

   // sample intake, ready leaves room for samples still in flight
   always_comb
   begin
      takeSample       = sampleValid && sampleReady;
      next_sampleReady = fifoInReady && fifoCount <= READY_LIMIT;
      next_chanDelayed = takeSample ? sampleChan : chanDelayed;
   end

   // steer a taken sample to the filter of its channel only
   always_comb
   begin
      for (int i = 0; i < `AIS_CHANNELS; i++)
         chanStrobe[i] = takeSample && (sampleChan == 2'(i));
   end

   // intake registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sampleReady <= 1'b0;
         chanDelayed <= 2'h0;
      end
      else
      begin
         sampleReady <= next_sampleReady;
         chanDelayed <= next_chanDelayed;
      end
   end

   // one independent filter and hysteresis per channel
   for (genvar g = 0; g < `AIS_CHANNELS; g++)
   begin : gChan
      ais_smooth_chan uChan
      (
         .clk          (clk),
         .rst_n        (rst_n),
         .sampleStrobe (chanStrobe[g]),
         .sampleData   (sampleData),
         .shiftSetting (shiftSet[g]),
         .hystWindow   (hystSet[g]),
         .acceptStrobe (chanAccept[g]),
         .activeValue  (chanActive[g])
      );
   end

   // accepted values go to the fifo with their global pin number
   always_comb
   begin
      pushPin     = addonOffset + `AIS_ANALOG_IN_BASE + {6'h00, chanDelayed};
      fifoInValid = |chanAccept;
      fifoInData  = {chanDelayed, pushPin, chanActive[chanDelayed]};
   end

   // eight-word queue between the channels and the output register
   ais_fifo #(
      .WIDTH (FW),
      .DEPTH (`AIS_FIFO_DEPTH)
   ) uFifo
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (fifoInData),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData),
      .count    (fifoCount)
   );

   // fields of the word at the head of the fifo
   assign headChan = fifoOutData[CH_HI:CH_LO];
   assign headPin  = fifoOutData[PIN_HI:PIN_LO];
   assign headData = fifoOutData[VAL_W-1:0];

   // output register refills when empty or being taken
   always_comb
   begin
      fifoOutReady  = !outValid || outReady;
      next_outValid = outValid && !outReady;
      next_outChan  = outChan;
      next_outPin   = outPin;
      next_outData  = outData;
      if (fifoOutValid && fifoOutReady)
      begin
         next_outValid = 1'b1;
         next_outChan  = headChan;
         next_outPin   = headPin;
         next_outData  = headData;
      end
   end

   // output register, held while the reader stalls
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         outValid <= 1'b0;
         outChan  <= 2'h0;
         outPin   <= 8'h00;
         outData  <= 12'h000;
      end
      else
      begin
         outValid <= next_outValid;
         outChan  <= next_outChan;
         outPin   <= next_outPin;
         outData  <= next_outData;
      end
   end

   // pin decode: global pin back to local, below the offset lies further left
   always_comb
   begin
      localPin      = readPin - addonOffset;
      analogSlot    = localPin - `AIS_ANALOG_IN_BASE;
      pinBelowAddon = readPin < addonOffset;
      pinAnalogIn   = !pinBelowAddon && localPin >= `AIS_ANALOG_IN_BASE &&
                      localPin <= `AIS_ANALOG_IN_LAST;
   end

   // pin readout: analog inputs answer with their active value
   always_comb
   begin
      next_readState = AIS_RD_IDLE;
      next_readData  = readData;
      if (readReq)
      begin
         case (addonKind)
            AIS_KIND_ANALOG:
            begin
               if (pinAnalogIn)
               begin
                  next_readState = AIS_RD_HIT;
                  next_readData  = chanActive[analogSlot[1:0]];
               end
               else
                  next_readState = AIS_RD_MISS;
            end
            AIS_KIND_RELAY:
            begin
               // relay inputs sit at 8 to 15 and are not analog
               // and relay outputs are never read back here
               if (localPin >= `AIS_RELAY_IN_BASE && localPin <= `AIS_RELAY_IN_LAST)
                  next_readState = AIS_RD_MISS;
               else
                  next_readState = AIS_RD_MISS;
            end
            default:
               next_readState = AIS_RD_MISS;
         endcase
      end
   end

   // read answer registers, one-cycle pulses
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         readData  <= 12'h000;
         readValid <= 1'b0;
         readMiss  <= 1'b0;
      end
      else
      begin
         readData  <= next_readData;
         readValid <= next_readState == AIS_RD_HIT;
         readMiss  <= next_readState == AIS_RD_MISS;
      end
   end
endmodule

/* File: verification/ais_adc_model.sv */
// adc partner: offers one sample at a time over valid/ready
// assumes the bench calls put just after a rising edge of clk
`timescale 1ns/100ps
module ais_adc_model
(
   input  wire logic   clk,
   input  wire logic   sampleReady,
   output logic        sampleValid,
   output logic [1:0]  sampleChan,
   output logic [11:0] sampleData
);
   // bus starts low with no offer
   initial
   begin
      sampleValid = 1'b0;
      sampleChan = 2'h0;
      sampleData = 12'h000;
   end
   // hold the offer until ready is seen or 20 edges pass, then show a stale pattern
   task automatic put(input logic [1:0] c, input logic [11:0] d, output bit took);
      int n;
      @(posedge clk);
      #1;
      took = 0;
      sampleValid = 1'b1;
      sampleChan = c;
      sampleData = d;
      for (n = 0; n < 20 && !took; n++)
      begin
         @(posedge clk);
         took = (sampleReady === 1'b1);
         #1;
      end
      sampleValid = 1'b0;
      sampleData = ~d;
   endtask
endmodule

/* File: verification/ais_top_asserts.sv */
// port checker for the smoothing block
// assumes bind onto ais_top, single clock domain
`timescale 1ns/100ps
module ais_top_asserts
   import ais_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        sampleValid,
   input wire logic        sampleReady,
   input wire logic        cfgWrite,
   input wire logic [4:0]  cfgShift,
   input wire logic        cfgReject,
   input wire ais_kind_t   addonKind,
   input wire ais_pin_t    addonOffset,
   input wire logic        readReq,
   input wire ais_pin_t    readPin,
   input wire logic        readValid,
   input wire logic        readMiss,
   input wire ais_sample_t readData,
   input wire logic        outValid,
   input wire logic [1:0]  outChan,
   input wire ais_pin_t    outPin,
   input wire ais_sample_t outData,
   input wire logic        outReady
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // pin decode of a read request
   logic [7:0] localPin;
   logic       hitPin;
   assign localPin = readPin - addonOffset;
   assign hitPin = addonKind == AIS_KIND_ANALOG && readPin >= addonOffset
      && localPin >= 8'h04 && localPin <= 8'h07;
   chk_out_stands: assert property (outValid && !outReady |=> outValid
      && $stable(outData) && $stable(outPin) && $stable(outChan))
      else $error("output changed while stalled");
   chk_out_pin: assert property (outValid |-> outPin == addonOffset + 8'h04 + outChan)
      else $error("output pin number wrong");
   chk_read_hit: assert property (readReq && hitPin |=> readValid && !readMiss)
      else $error("analog input read not answered");
   chk_read_miss: assert property (readReq && !hitPin |=> readMiss && !readValid)
      else $error("read outside inputs not refused");
   chk_read_idle: assert property (!readReq |=> !readValid && !readMiss)
      else $error("read answer without request");
   chk_read_hold: assert property (!readValid |-> $stable(readData))
      else $error("read data moved without answer");
   chk_cfg_reject: assert property (cfgWrite && cfgShift > 5'h10 |=> cfgReject)
      else $error("order above 16 not refused");
   chk_cfg_ok: assert property (!(cfgWrite && cfgShift > 5'h10) |=> !cfgReject)
      else $error("legal order refused");
   cov_read_hit: cover property (readReq && hitPin);
   cov_cfg_bad: cover property (cfgWrite && cfgShift > 5'h10);
   cov_refused: cover property (sampleValid && !sampleReady);
   cov_stall: cover property (outValid && !outReady);
endmodule
bind ais_top ais_top_asserts chk (.clk(clk), .rst_n(rst_n), .sampleValid(sampleValid),
   .sampleReady(sampleReady), .cfgWrite(cfgWrite), .cfgShift(cfgShift),
   .cfgReject(cfgReject), .addonKind(addonKind), .addonOffset(addonOffset),
   .readReq(readReq), .readPin(readPin), .readValid(readValid), .readMiss(readMiss),
   .readData(readData), .outValid(outValid), .outChan(outChan), .outPin(outPin),
   .outData(outData), .outReady(outReady));

/* File: verification/tb.sv */
// self-checking bench for the smoothing block
// assumes the adc model drives the sample port
`timescale 1ns/100ps
module tb;
   import ais_pkg::*;
   logic        clk, rst_n, sampleValid, sampleReady, cfgWrite, cfgReject;
   logic        readReq, readValid, readMiss, outValid, outReady;
   logic [1:0]  sampleChan, cfgChan, outChan;
   logic [4:0]  cfgShift;
   ais_sample_t sampleData, cfgHyst, readData, outData;
   ais_kind_t   addonKind;
   ais_pin_t    addonOffset, readPin, outPin;
   int          err_total, comparisons;
   bit          took;
   ais_top dut (.clk(clk), .rst_n(rst_n), .sampleValid(sampleValid),
      .sampleChan(sampleChan), .sampleData(sampleData), .sampleReady(sampleReady),
      .cfgWrite(cfgWrite), .cfgChan(cfgChan), .cfgShift(cfgShift), .cfgHyst(cfgHyst),
      .cfgReject(cfgReject), .addonKind(addonKind), .addonOffset(addonOffset),
      .readReq(readReq), .readPin(readPin), .readValid(readValid), .readMiss(readMiss),
      .readData(readData), .outValid(outValid), .outChan(outChan), .outPin(outPin),
      .outData(outData), .outReady(outReady));
   ais_adc_model adc (.clk(clk), .sampleReady(sampleReady), .sampleValid(sampleValid),
      .sampleChan(sampleChan), .sampleData(sampleData));
   // 200 MHz clock
   always #2.5 clk = ~clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one offered sample that must be taken
   task automatic put1(input logic [1:0] c, input logic [11:0] d);
      adc.put(c, d, took);
      chk(took, 1);
   endtask
   // wait for one accepted value and compare it
   task automatic get(input logic [1:0] c, input logic [11:0] d);
      int n;
      bit seen;
      seen = 0;
      for (n = 0; n < 20 && !seen; n++)
      begin
         @(posedge clk);
         if (outValid === 1'b1)
         begin
            seen = 1;
            chk(outChan, c);
            chk(outPin, addonOffset + 8'h04 + c);
            chk(outData, d);
         end
         #1;
      end
      chk(seen, 1);
   endtask
   // no value may come out
   task automatic none();
      repeat (6)
      begin
         @(posedge clk);
         #1;
         chk(outValid, 0);
      end
   endtask
   task automatic rd(input ais_pin_t p, input logic v, input logic [11:0] d);
      @(posedge clk);
      #1;
      readReq = 1'b1;
      readPin = p;
      @(posedge clk);
      #1;
      readReq = 1'b0;
      chk(readValid, v);
      chk(readMiss, !v);
      if (v)
         chk(readData, d);
   endtask
   task automatic cfg(input logic [1:0] c, input logic [4:0] s, input logic [11:0] h,
      input logic r);
      @(posedge clk);
      #1;
      cfgWrite = 1'b1;
      cfgChan = c;
      cfgShift = s;
      cfgHyst = h;
      @(posedge clk);
      #1;
      cfgWrite = 1'b0;
      chk(cfgReject, r);
   endtask
   // reset order 3 ramps from zero; default window drops a step of 3
   task automatic t_defaults();
      put1(2'h0, 12'h800);
      get(2'h0, 12'h100);
      put1(2'h0, 12'h800);
      get(2'h0, 12'h1E0);
      put1(2'h1, 12'h020);
      get(2'h1, 12'h004);
      put1(2'h1, 12'h020);
      none();
      put1(2'h1, 12'h020);
      get(2'h1, 12'h00A);
      $display("test defaults done");
   endtask
   // order 0 passes samples; edges of the window are dropped
   task automatic t_window();
      cfg(2'h3, 5'h00, 12'h010, 1'b0);
      put1(2'h3, 12'h100);
      get(2'h3, 12'h100);
      put1(2'h3, 12'h110);
      none();
      put1(2'h3, 12'h0F0);
      none();
      put1(2'h3, 12'h111);
      get(2'h3, 12'h111);
      $display("test window done");
   endtask
   // pin numbering with and without an offset, relay kind
   task automatic t_reads();
      rd(8'h13, 1'b1, 12'h111);
      rd(8'h11, 1'b1, 12'h00A);
      rd(8'h0F, 1'b0, 12'h000);
      rd(8'h14, 1'b0, 12'h000);
      rd(8'h03, 1'b0, 12'h000);
      addonKind = AIS_KIND_RELAY;
      rd(8'h13, 1'b0, 12'h000);
      addonKind = AIS_KIND_ANALOG;
      addonOffset = 8'h00;
      rd(8'h07, 1'b1, 12'h111);
      addonOffset = 8'h0C;
      $display("test reads done");
   endtask
   // orders above 16 refused and leave settings; order 16 kept
   task automatic t_config();
      cfg(2'h0, 5'h11, 12'h000, 1'b1);
      cfg(2'h0, 5'h1F, 12'h000, 1'b1);
      put1(2'h0, 12'h800);
      get(2'h0, 12'h2A4);
      cfg(2'h2, 5'h10, 12'h000, 1'b0);
      put1(2'h2, 12'hFFF);
      get(2'h2, 12'h000);
      $display("test config done");
   endtask
   // stall the reader until samples are refused, then drain in order
   task automatic t_fifo();
      int i, n;
      n = 0;
      cfg(2'h2, 5'h00, 12'h000, 1'b0);
      outReady = 1'b0;
      for (i = 0; i < 12; i++)
      begin
         adc.put(2'h2, i[0] ? 12'h000 : 12'hFFF, took);
         if (!took)
            break;
         n++;
      end
      chk(n >= 6 && n < 12, 1);
      outReady = 1'b1;
      for (i = 0; i < n; i++)
         get(2'h2, i[0] ? 12'h000 : 12'hFFF);
      none();
      $display("test fifo done");
   endtask
   // reset, then the scenarios
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      {cfgWrite, cfgChan, cfgShift, cfgHyst, readReq, readPin} = '0;
      addonKind = AIS_KIND_ANALOG;
      addonOffset = 8'h0C;
      outReady = 1'b1;
      err_total = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_defaults();
      t_window();
      t_reads();
      t_config();
      t_fifo();
      stop_test();
   end
endmodule
